// ---- design/fskrx_consts.svh ----
// Constants for the FSK receive path control block
`ifndef FSKRX_CONSTS_SVH
`define FSKRX_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FSKRX_OFS_MODE     12'h000
`define FSKRX_OFS_CTRL     12'h004
`define FSKRX_OFS_STAT     12'h008
`define FSKRX_OFS_CNT      12'h00c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FSKRX_MODE_DEMOD   1
`define FSKRX_MODE_BAND_LO 4
`define FSKRX_MODE_BAND_HI 5
`define FSKRX_MODE_EQ      6
`define FSKRX_MODE_RST     8'h00
`define FSKRX_CTRL_STBY    0
`define FSKRX_CTRL_RST     1'h0
`define FSKRX_STAT_OVF     8
`define FSKRX_BAND_CALL    2'h0
`define FSKRX_BAND_UNDEF   2'h1
`define FSKRX_BAND_LOW     2'h2
`define FSKRX_BAND_HIGH    2'h3

// ----------------------------------------------------------------
// Timing: reference rate and discriminator split frequencies
// ----------------------------------------------------------------
`define FSKRX_XTAL_HZ      3579545
`define FSKRX_HI_MID_HZ    1700
`define FSKRX_LO_MID_HZ    425
`define FSKRX_HI_THR       (`FSKRX_XTAL_HZ / (2 * `FSKRX_HI_MID_HZ))
`define FSKRX_LO_THR       (`FSKRX_XTAL_HZ / (2 * `FSKRX_LO_MID_HZ))

`endif

// ---- design/fskrx_pkg.sv ----
// Types for the FSK receive path control block
package fskrx_pkg;

	typedef enum logic [2:0]
	{
		FSKRX_FILT_CALL = 3'b001,
		FSKRX_FILT_LOW  = 3'b010,
		FSKRX_FILT_HIGH = 3'b100
	} fskrx_filt_e;

	typedef logic [15:0] fskrx_cnt_t;

endpackage

// ---- design/fskrx_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module fskrx_fifo
	import fskrx_pkg::*;
#(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
)
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    wr_d;
	logic [AW-1:0]    rd_q;
	logic [AW-1:0]    rd_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	// ----------------------------------------------------------------
	// Pointers and count
	// ----------------------------------------------------------------
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];
	assign level     = cnt_q;

	always_comb
	begin
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push)
		begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
		end
		if (pop)
		begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
		end
		if (push && !pop)
		begin
			cnt_d = (AW+1)'(cnt_q + 1'b1);
		end
		else if (pop && !push)
		begin
			cnt_d = (AW+1)'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Storage needs no reset; out_data is only meaningful with out_valid
	always_ff @(posedge pclk)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data;
		end
	end

endmodule

`default_nettype wire

// ---- design/fskrx_ctrl.sv ----
// FSK receive path control: setup register, filter selects, demodulator
`timescale 1ns/1ns
`default_nettype none
`include "fskrx_consts.svh"

module fskrx_ctrl
	import fskrx_pkg::*;
#(
	parameter int HI_THR    = `FSKRX_HI_THR,
	parameter int LO_THR    = `FSKRX_LO_THR,
	parameter int FIFO_DEP  = 4
)
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Reference clock pin and oscillator control
	input  wire logic        xtal_clk,
	output logic             osc_en,
	// Sliced receive line from the filter
	input  wire logic        rx_line,
	// Analogue path selects
	output logic [2:0]       filt_sel,
	output logic             eq_en,
	output logic             demod_en,
	// Stream to receive UART
	output logic             rx_data,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic [16:0]      rx_word
);

	localparam int FW = 17;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0]  mode_q;
	logic [7:0]  mode_d;
	logic        stby_q;
	logic        stby_d;
	logic        ovf_q;
	logic        ovf_d;
	logic [15:0] nbits_q;
	logic [15:0] nbits_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic        err_q;
	logic        err_d;

	logic        setup_ph;
	logic        wr_acc;
	logic        hit;
	logic [31:0] rd_mux;
	logic [1:0]  band;
	logic [$clog2(FIFO_DEP):0] fifo_lvl;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// Band from setup bits
	assign band = {mode_q[`FSKRX_MODE_BAND_HI], mode_q[`FSKRX_MODE_BAND_LO]};

	always_comb
	begin
		unique case (band)
			`FSKRX_BAND_LOW:  filt_sel = FSKRX_FILT_LOW;
			`FSKRX_BAND_HIGH: filt_sel = FSKRX_FILT_HIGH;
			// Undefined code keeps the widest-use call progress band
			default:          filt_sel = FSKRX_FILT_CALL;
		endcase
	end

	assign eq_en = mode_q[`FSKRX_MODE_EQ] && (band == `FSKRX_BAND_HIGH);

	assign demod_en = mode_q[`FSKRX_MODE_DEMOD] && mode_q[`FSKRX_MODE_BAND_HI];

	// Bus access keeps working while the oscillator is stopped
	// Oscillator off in standby
	assign osc_en = !stby_q;

	// ----------------------------------------------------------------
	// Reference clock and line synchronisers
	// ----------------------------------------------------------------
	logic [2:0] xs_q;
	logic [2:0] xs_d;
	logic [2:0] ls_q;
	logic [2:0] ls_d;
	logic [2:0] lv_q;
	logic [2:0] lv_d;
	logic       xtal_tick;
	logic       line_edge;

	always_comb
	begin
		xs_d = {xs_q[1:0], xtal_clk};
		ls_d = {ls_q[1:0], rx_line};
		lv_d = {lv_q[1:0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xs_q <= '0;
			ls_q <= '0;
			lv_q <= '0;
		end
		else
		begin
			xs_q <= xs_d;
			ls_q <= ls_d;
			lv_q <= lv_d;
		end
	end

	// Timebase from reference edges
	// Standby drops ticks, so a word measured across it reads short
	assign xtal_tick = xs_q[1] && !xs_q[2] && !stby_q;
	// Reset contents are not line samples, so no false crossing
	assign line_edge = (ls_q[1] ^ ls_q[2]) && lv_q[2];

	// ----------------------------------------------------------------
	// Discriminator: half-period length in reference ticks
	// ----------------------------------------------------------------
	fskrx_cnt_t  hp_q;
	fskrx_cnt_t  hp_d;
	logic        bit_q;
	logic        bit_d;
	logic        push;
	logic        in_ready;
	fskrx_cnt_t  thr;

	// Low-speed split sits between both 75 and 150 bps tone pairs
	assign thr  = (band == `FSKRX_BAND_HIGH) ? 16'(HI_THR) : 16'(LO_THR);
	assign push = demod_en && line_edge;

	always_comb
	begin
		hp_d  = hp_q;
		bit_d = bit_q;
		if (line_edge)
		begin
			hp_d = '0;
		end
		else if (xtal_tick && (hp_q != '1))
		begin
			// Saturates so a silent line reads as a long mark
			hp_d = fskrx_cnt_t'(hp_q + 1'b1);
		end
		if (!demod_en)
		begin
			bit_d = 1'b1;
		end
		else if (line_edge)
		begin
			// Longer half period means lower tone, mark
			bit_d = (hp_q > thr);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hp_q  <= '0;
			bit_q <= 1'b1;
		end
		else
		begin
			hp_q  <= hp_d;
			bit_q <= bit_d;
		end
	end

	// No validity gating, host uses energy detector
	assign rx_data = bit_q;

	// ----------------------------------------------------------------
	// Word buffer toward the UART
	// ----------------------------------------------------------------
	// Words arriving while full are dropped and flagged in status
	fskrx_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEP)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (push),
		.in_ready  (in_ready),
		.in_data   ({(hp_q > thr), hp_q}),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_word),
		.level     (fifo_lvl)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; read data is captured in the setup cycle
	// so it stands unchanged through the access cycle
	assign setup_ph = psel && !penable;
	assign pready   = psel && penable;
	assign wr_acc   = pready && pwrite;
	assign prdata   = rdat_q;
	assign pslverr  = pready && err_q;

	always_comb
	begin
		hit    = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			`FSKRX_OFS_MODE: rd_mux = {24'h0, mode_q};
			`FSKRX_OFS_CTRL: rd_mux = {31'h0, stby_q};
			`FSKRX_OFS_STAT:
			begin
				rd_mux = {20'h0, 3'(fifo_lvl), ovf_q, rx_data, demod_en,
					eq_en, osc_en, 1'b0, filt_sel};
			end
			`FSKRX_OFS_CNT:  rd_mux = {16'h0, nbits_q};
			default:         hit = 1'b0;
		endcase
	end

	always_comb
	begin
		mode_d  = mode_q;
		stby_d  = stby_q;
		ovf_d   = ovf_q;
		nbits_d = nbits_q;
		rdat_d  = rdat_q;
		err_d   = err_q;
		if (setup_ph)
		begin
			rdat_d = pwrite ? 32'h0 : rd_mux;
			err_d  = !hit;
		end
		if (wr_acc && (paddr == `FSKRX_OFS_MODE))
		begin
			mode_d = pwdata[7:0];
		end
		if (wr_acc && (paddr == `FSKRX_OFS_CTRL))
		begin
			// Host sets standby before stopping its clock
			stby_d = pwdata[`FSKRX_CTRL_STBY];
		end
		if (wr_acc && (paddr == `FSKRX_OFS_STAT) && pwdata[`FSKRX_STAT_OVF])
		begin
			ovf_d = 1'b0;
		end
		if (wr_acc && (paddr == `FSKRX_OFS_CNT))
		begin
			nbits_d = '0;
		end
		// Set wins over a clear in the same cycle
		if (push && !in_ready)
		begin
			ovf_d = 1'b1;
		end
		if (push && in_ready)
		begin
			// Builds on a clear in the same cycle, so that word counts as one
			nbits_d = 16'(nbits_d + 1'b1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q  <= `FSKRX_MODE_RST;
			stby_q  <= `FSKRX_CTRL_RST;
			ovf_q   <= 1'b0;
			nbits_q <= '0;
			rdat_q  <= '0;
			err_q   <= 1'b0;
		end
		else
		begin
			mode_q  <= mode_d;
			stby_q  <= stby_d;
			ovf_q   <= ovf_d;
			nbits_q <= nbits_d;
			rdat_q  <= rdat_d;
			err_q   <= err_d;
		end
	end

endmodule

`default_nettype wire

// ---- dv/fskrx_assertions.sv ----
// Port checker for the receive path control block
`timescale 1ns/1ns
`default_nettype none

module fskrx_assertions
	import fskrx_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Path selects
	input wire logic        osc_en,
	input wire logic [2:0]  filt_sel,
	input wire logic        eq_en,
	input wire logic        demod_en,
	// Stream
	input wire logic        rx_data,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic [16:0] rx_word
);
	// ----------------------
	// Register shadow
	// ----------------------
	logic [7:0] mode_q, mode_d;
	logic       stby_q, stby_d;
	logic       wr;
	assign wr = psel && penable && pwrite;
	always_comb
	begin
		mode_d = mode_q;
		stby_d = stby_q;
		if (wr && paddr == 12'h000)
			mode_d = pwdata[7:0];
		if (wr && paddr == 12'h004)
			stby_d = pwdata[0];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= 8'h00;
			stby_q <= 1'h0;
		end
		else
		begin
			mode_q <= mode_d;
			stby_q <= stby_d;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------
	// Checks
	// ----------------------
	a_osc_standby: assert property (osc_en == !stby_q)
		else $error("oscillator enable wrong");
	a_band_onehot: assert property ($onehot(filt_sel))
		else $error("band select not one-hot");
	a_band_decode: assert property
		(filt_sel == (mode_q[5] ? (mode_q[4] ? 3'h4 : 3'h2) : 3'h1))
		else $error("band decode wrong");
	a_eq_gate: assert property (eq_en == (mode_q[6] && mode_q[5:4] == 2'h3))
		else $error("equaliser enable wrong");
	a_demod_gate: assert property (demod_en == (mode_q[1] && mode_q[5]))
		else $error("demodulator enable wrong");
	a_word_hold: assert property
		(rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
		else $error("word lost while stalled");
	a_data_bit: assert property ($rose(rx_valid) |-> rx_data == rx_word[16])
		else $error("data level differs from word");
	a_mark_idle: assert property (!demod_en [*2] |-> rx_data)
		else $error("data line not at mark");
endmodule

bind fskrx_ctrl fskrx_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .osc_en, .filt_sel, .eq_en, .demod_en, .rx_data, .rx_valid,
	.rx_ready, .rx_word);

`default_nettype wire

// ---- dv/fskrx_line_src.sv ----
// Reference clock and sliced line source
`timescale 1ns/1ns
`default_nettype none

module fskrx_line_src
(
	// Controls
	input  wire logic        run,
	input  wire logic [15:0] half,
	// Pins
	output var logic         xtal_clk,
	output var logic         rx_line
);
	// ----------------------
	// Sources
	// ----------------------
	// clock stops only while run is low
	initial
	begin
		xtal_clk = 0;
		// Nearest half period to the reference rate at this resolution
		forever #140 xtal_clk = run & ~xtal_clk;
	end
	initial
	begin
		rx_line = 1;
		wait (half != 16'h0000);
		forever #(half) rx_line = ~rx_line;
	end
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// Register and stream bench for the receive path control block
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        xtal_clk, osc_en, rx_line, eq_en, demod_en;
	logic        rx_data, rx_valid, rx_ready, run, e;
	logic [2:0]  filt_sel;
	logic [16:0] rx_word;
	logic [15:0] half;
	logic [7:0]  m;
	int          n_mismatch, num_checks;

	fskrx_ctrl #(.HI_THR(4), .LO_THR(10), .FIFO_DEP(4)) DUT (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.xtal_clk, .osc_en, .rx_line, .filt_sel, .eq_en, .demod_en, .rx_data,
		.rx_valid, .rx_ready, .rx_word);
	fskrx_line_src u_src (.run, .half, .xtal_clk, .rx_line);

	// ----------------------
	// Tasks
	// ----------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x)
		begin
			$display("Error at %0t: got %h exp %h", $time, g, x);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
		begin
			$display("Error at %0t: no ready from slave", $time);
			n_mismatch++;
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk(r, x);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------
	// Clock, watchdog, tests
	// ----------------------
	initial
	begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	initial
	begin
		#200000;
		n_mismatch++;
		test_done();
	end
	initial
	begin
		{psel, penable, pwrite, rx_ready, presetn} = 0;
		paddr = 0;
		pwdata = 0;
		run = 1;
		half = 16'h0690;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk(osc_en, 1);
		chk(rx_data, 1);
		rd(12'h000, 0);
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			m = {1'b0, i[3:1], 2'b0, i[0], 1'b0};
			apb(1, 12'h000, m);
			@(negedge pclk);
			chk(filt_sel, m[5] ? (m[4] ? 4 : 2) : 1);
			chk(eq_en, m[6] & m[5] & m[4]);
			chk(demod_en, m[1] & m[5]);
		end
		apb(1, 12'h010, 0);
		chk(e, 1);
		rd(12'h000, 8'h72);
		$display("mode test done");
		apb(1, 12'h00c, 0);
		repeat (3000) @(posedge pclk);
		rd(12'h008, 32'h9f4);
		repeat (4)
		begin
			@(negedge pclk);
			chk(rx_word[16], 1);
			chk(rx_valid, 1);
			@(posedge pclk);
			rx_ready <= 1;
			@(posedge pclk);
			rx_ready <= 0;
		end
		apb(1, 12'h008, 32'h100);
		half <= 16'h0230;
		rx_ready <= 1;
		repeat (1000) @(posedge pclk);
		apb(0, 12'h008, 0);
		chk(r[8:0], 9'h074);
		$display("stream test done");
		apb(1, 12'h000, 8'h30);
		apb(1, 12'h00c, 0);
		repeat (2000) @(posedge pclk);
		rd(12'h00c, 0);
		chk(rx_data, 1);
		$display("idle test done");
		apb(1, 12'h004, 1);
		@(negedge pclk);
		chk(osc_en, 0);
		run <= 0;
		repeat (100) @(posedge pclk);
		run <= 1;
		apb(1, 12'h004, 0);
		@(negedge pclk);
		chk(osc_en, 1);
		$display("standby test done");
		test_done();
	end
endmodule

`default_nettype wire
